// [logic/hop_defines.svh]
/*
  Offsets, field positions, reset values and timing counts for the burst
  frequency hop controller. Assumes inclusion by bare name from logic/.
*/
`ifndef HOP_DEFINES_SVH
`define HOP_DEFINES_SVH
// Register indices; the byte address is four times the index.
`define IDX_HOP_MODE 8'hf4
`define IDX_DELAY_PRI 8'hf5
`define IDX_DELAY_SEC 8'hf6
`define IDX_DELAY_TER 8'hf7
`define IDX_NOISE_CFG 8'hf8
`define IDX_OFFSET_FIRST 8'hfa
`define IDX_OFFSET_SECOND 8'hfb
`define IDX_STATUS 8'hfc
// Field positions.
`define HOP_MODE_MSB 7
`define HOP_MODE_LSB 6
`define LIMIT_MSB 7
`define LIMIT_LSB 4
`define THR_IDX_MSB 3
`define THR_IDX_LSB 0
// Reset values.
`define RST_HOP_MODE 2'h3
`define RST_DELAY_PRI 8'h01
`define RST_DELAY_SEC 8'h06
`define RST_DELAY_TER 8'h3f
`define RST_NOISE_CFG 8'h32
`define RST_OFFSET 8'h00
// Noise threshold table: base and step in counts.
`define THR_BASE 8'h05
`define THR_STEP 8'h03
// Timing.
`define CLK_HZ 20000000
`define RESTORE_MS 1000
`define RESTORE_CYCLES ((`RESTORE_MS) * ((`CLK_HZ) / 1000))
`endif

// [logic/hop_pkg.sv]
/*
  Types shared by the hop controller files. Assumes nothing else.
*/
package hop_pkg;
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_RECAL = 2'h1,
    MODE_ADJUST = 2'h2,
    MODE_SWEEP = 2'h3
  } hop_mode_t;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h1,
    BUS_WR = 3'h2,
    BUS_RD = 3'h4
  } bus_state_t;
endpackage

// [logic/noise_integrators.sv]
/*
  Noise threshold lookup and the two noise integrators.
  Assumes deltas and scan end arrive from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "hop_defines.svh"
module noise_integrators (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Configuration and sample stream.
  input wire logic enable,
  input wire logic [3:0] thr_index,
  input wire logic delta_valid,
  input wire logic signed [15:0] delta,
  input wire logic scan_end,
  // Counts.
  output logic [3:0] pos_count_r,
  output logic [3:0] neg_count_r
);
  logic [7:0] thr;
  logic [15:0] mag;
  logic noisy;

  // Linear table: index 0 is 5 counts, 2 is 11, 15 is 50.
  assign thr = `THR_BASE + 8'(thr_index) * `THR_STEP;
  assign mag = delta[15] ? 16'(-delta) : 16'(delta);
  assign noisy = enable && delta_valid && (mag >= {8'h00, thr});

  // Counters saturate at 15 so a long burst cannot wrap below the limit.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_count_r <= 4'h0;
      neg_count_r <= 4'h0;
    end else if (scan_end) begin
      pos_count_r <= 4'h0;
      neg_count_r <= 4'h0;
    end else if (noisy) begin
      if (!delta[15] && pos_count_r != 4'hf) begin
        pos_count_r <= pos_count_r + 4'h1;
      end
      if (delta[15] && neg_count_r != 4'hf) begin
        neg_count_r <= neg_count_r + 4'h1;
      end
    end
  end

  // Scan end always leaves both counters at zero.
  integ_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    scan_end |=> (pos_count_r == 4'h0 && neg_count_r == 4'h0))
    else $error("integrators not cleared after scan end");
endmodule
`default_nettype wire

// [logic/prd_timer.sv]
/*
  Positive recalibration delay timer.
  Assumes the excursion level comes from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module restore_timer #(
  parameter int unsigned RESTORE_CYCLES = 20000000
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Excursion in, restore pulse out.
  input wire logic pos_excursion,
  output logic restore_r
);
  logic [24:0] count_r;

  // The excursion must hold without a break for the whole fixed delay.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= 25'h0;
      restore_r <= 1'b0;
    end else if (!pos_excursion) begin
      count_r <= 25'h0;
      restore_r <= 1'b0;
    end else if (count_r == 25'(RESTORE_CYCLES - 1)) begin
      count_r <= 25'h0;
      restore_r <= 1'b1;
    end else begin
      count_r <= count_r + 25'h1;
      restore_r <= 1'b0;
    end
  end

  // A restore needs an unbroken excursion in the cycle before.
  restore_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
    restore_r |-> $past(pos_excursion))
    else $error("restore without excursion");
endmodule
`default_nettype wire

// [logic/burst_frequency_hop_control.sv]
/*
  Burst frequency hop controller: setup registers over AHB-Lite, fixed,
  hopping and sweeping idle time selection, and key reference requests.
  Assumes key deltas, scan end, calibration status and excursion come
  from logic on the same clock; the burst generator reads idle_cycles_r.
*/
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "hop_defines.svh"
module burst_frequency_hop_control #(
  parameter int unsigned RESTORE_CYCLES = `RESTORE_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Acquisition side.
  input wire logic delta_valid,
  input wire logic signed [15:0] delta,
  input wire logic scan_end,
  input wire logic calib_busy,
  input wire logic pos_excursion,
  // Burst timing and reference requests.
  output logic [8:0] idle_cycles_r,
  output logic hop_r,
  output logic recal_all_r,
  output logic adjust_ref_r,
  output logic [7:0] freq_offset_first_r,
  output logic [7:0] freq_offset_second_r,
  output logic restore_r
);
  hop_pkg::bus_state_t bus_state_r;
  hop_pkg::hop_mode_t hop_mode_select_r;
  logic [7:0] addr_idx_r;
  logic [7:0] delay_setting_primary_r;
  logic [7:0] delay_setting_secondary_r;
  logic [7:0] delay_setting_tertiary_r;
  logic [7:0] noise_cfg_r;
  logic hready_r;
  logic [31:0] rdata_r;
  logic [3:0] pos_count;
  logic [3:0] neg_count;
  logic [1:0] rot_idx_r;
  logic [8:0] sweep_r;
  logic sweep_down_r;
  logic [8:0] idle_nxt;
  logic [8:0] pri_eff;
  logic [8:0] sec_eff;
  logic [8:0] ter_eff;
  logic [3:0] noise_integrator_limit;
  logic [3:0] noise_threshold_index;
  logic hop_mode_noise;
  logic hop_go;
  logic accept;
  logic wr_en;
  logic [31:0] rd_mux;

  // Zero in a delay setting stands for the longest gap.
  function automatic logic [8:0] delay_eff(input logic [7:0] v);
    delay_eff = (v == 8'h00) ? 9'h100 : {1'b0, v};
  endfunction

  assign pri_eff = delay_eff(delay_setting_primary_r);
  assign sec_eff = delay_eff(delay_setting_secondary_r);
  assign ter_eff = delay_eff(delay_setting_tertiary_r);
  assign noise_integrator_limit = noise_cfg_r[`LIMIT_MSB:`LIMIT_LSB];
  assign noise_threshold_index = noise_cfg_r[`THR_IDX_MSB:`THR_IDX_LSB];
  assign hop_mode_noise = (hop_mode_select_r == hop_pkg::MODE_RECAL) ||
    (hop_mode_select_r == hop_pkg::MODE_ADJUST);
  assign hreadyout = hready_r;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  // Bus phases. Reads take one wait state so that a write just before
  // is already stored when the read mux is sampled.
  assign accept = hsel && htrans[1] && hready;
  assign wr_en = (bus_state_r == hop_pkg::BUS_WR);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_state_r <= hop_pkg::BUS_IDLE;
      hready_r <= 1'b1;
      addr_idx_r <= 8'h00;
    end else begin
      unique case (bus_state_r)
        hop_pkg::BUS_RD: begin
          hready_r <= 1'b1;
          bus_state_r <= hop_pkg::BUS_IDLE;
        end
        hop_pkg::BUS_IDLE, hop_pkg::BUS_WR: begin
          if (accept) begin
            // Anything outside the low ten bits lands on no register.
            addr_idx_r <= (haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0) ?
              haddr[9:2] : 8'h00;
            if (hwrite) begin
              bus_state_r <= hop_pkg::BUS_WR;
            end else begin
              bus_state_r <= hop_pkg::BUS_RD;
              hready_r <= 1'b0;
            end
          end else begin
            bus_state_r <= hop_pkg::BUS_IDLE;
          end
        end
        default: begin
          bus_state_r <= hop_pkg::BUS_IDLE;
          hready_r <= 1'b1;
        end
      endcase
    end
  end

  // Read mux; unmapped words and unused bits read as zero.
  always_comb begin
    rd_mux = 32'h0;
    unique case (addr_idx_r)
      `IDX_HOP_MODE: rd_mux[`HOP_MODE_MSB:`HOP_MODE_LSB] = hop_mode_select_r;
      `IDX_DELAY_PRI: rd_mux[7:0] = delay_setting_primary_r;
      `IDX_DELAY_SEC: rd_mux[7:0] = delay_setting_secondary_r;
      `IDX_DELAY_TER: rd_mux[7:0] = delay_setting_tertiary_r;
      `IDX_NOISE_CFG: rd_mux[7:0] = noise_cfg_r;
      `IDX_OFFSET_FIRST: rd_mux[7:0] = freq_offset_first_r;
      `IDX_OFFSET_SECOND: rd_mux[7:0] = freq_offset_second_r;
      // Status is read only; the pad keeps the concat a full word wide.
      `IDX_STATUS: rd_mux = {11'h0, calib_busy, sweep_down_r, rot_idx_r,
        pos_count, neg_count, idle_cycles_r};
      default: rd_mux = 32'h0;
    endcase
  end

  // Read data is loaded during the wait state.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 32'h0;
    end else if (bus_state_r == hop_pkg::BUS_RD) begin
      rdata_r <= rd_mux;
    end
  end

  // Setup registers, written in the data phase from the low byte.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hop_mode_select_r <= hop_pkg::hop_mode_t'(`RST_HOP_MODE);
      delay_setting_primary_r <= `RST_DELAY_PRI;
      delay_setting_secondary_r <= `RST_DELAY_SEC;
      delay_setting_tertiary_r <= `RST_DELAY_TER;
      noise_cfg_r <= `RST_NOISE_CFG;
      freq_offset_first_r <= `RST_OFFSET;
      freq_offset_second_r <= `RST_OFFSET;
    end else if (wr_en) begin
      unique case (addr_idx_r)
        `IDX_HOP_MODE: hop_mode_select_r <= hop_pkg::hop_mode_t'(
          hwdata[`HOP_MODE_MSB:`HOP_MODE_LSB]);
        `IDX_DELAY_PRI: delay_setting_primary_r <= hwdata[7:0];
        `IDX_DELAY_SEC: delay_setting_secondary_r <= hwdata[7:0];
        `IDX_DELAY_TER: delay_setting_tertiary_r <= hwdata[7:0];
        `IDX_NOISE_CFG: noise_cfg_r <= hwdata[7:0];
        `IDX_OFFSET_FIRST: freq_offset_first_r <= hwdata[7:0];
        `IDX_OFFSET_SECOND: freq_offset_second_r <= hwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Noise integrators run only where hopping is noise driven.
  noise_integrators u_integ (
    .clk(clk),
    .arst_n(arst_n),
    .enable(hop_mode_noise),
    .thr_index(noise_threshold_index),
    .delta_valid(delta_valid),
    .delta(delta),
    .scan_end(scan_end),
    .pos_count_r(pos_count),
    .neg_count_r(neg_count)
  );

  // Hop decision at scan end, before the counters clear; never while
  // calibrating, since references are not yet valid at the new delay.
  assign hop_go = hop_mode_noise && scan_end && !calib_busy &&
    (pos_count >= noise_integrator_limit) &&
    (neg_count >= noise_integrator_limit);

  // Rotation index over the three settings.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rot_idx_r <= 2'h0;
    end else if (!hop_mode_noise) begin
      rot_idx_r <= 2'h0;
    end else if (hop_go) begin
      rot_idx_r <= (rot_idx_r == 2'h2) ? 2'h0 : rot_idx_r + 2'h1;
    end
  end

  // Sweep position; a host breaking the bound ordering gets an
  // oscillation at the edge rather than a lockup.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sweep_r <= 9'h001;
      sweep_down_r <= 1'b0;
    end else if (hop_mode_select_r != hop_pkg::MODE_SWEEP) begin
      sweep_r <= pri_eff;
      sweep_down_r <= 1'b0;
    end else if (scan_end) begin
      if (!sweep_down_r && sweep_r >= sec_eff) begin
        sweep_down_r <= 1'b1;
        sweep_r <= sweep_r - 9'h001;
      end else if (sweep_down_r && sweep_r <= pri_eff) begin
        sweep_down_r <= 1'b0;
        sweep_r <= sweep_r + 9'h001;
      end else if (sweep_down_r) begin
        sweep_r <= sweep_r - 9'h001;
      end else begin
        sweep_r <= sweep_r + 9'h001;
      end
    end
  end

  // Idle gap by mode; a larger nonzero setting gives a longer gap.
  always_comb begin
    idle_nxt = pri_eff;
    unique case (hop_mode_select_r)
      hop_pkg::MODE_OFF: idle_nxt = pri_eff;
      hop_pkg::MODE_RECAL, hop_pkg::MODE_ADJUST: begin
        unique case (rot_idx_r)
          2'h1: idle_nxt = sec_eff;
          2'h2: idle_nxt = ter_eff;
          default: idle_nxt = pri_eff;
        endcase
      end
      hop_pkg::MODE_SWEEP: idle_nxt = sweep_r;
    endcase
  end

  // Idle output and reference requests; the sweep never asks for one.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_cycles_r <= 9'h001;
      hop_r <= 1'b0;
      recal_all_r <= 1'b0;
      adjust_ref_r <= 1'b0;
    end else begin
      idle_cycles_r <= idle_nxt;
      hop_r <= hop_go ||
        (hop_mode_select_r == hop_pkg::MODE_SWEEP && scan_end);
      recal_all_r <= hop_go &&
        (hop_mode_select_r == hop_pkg::MODE_RECAL);
      adjust_ref_r <= hop_go &&
        (hop_mode_select_r == hop_pkg::MODE_ADJUST);
    end
  end

  // Fixed restore delay after an upward excursion.
  restore_timer #(
    .RESTORE_CYCLES(RESTORE_CYCLES)
  ) u_restore (
    .clk(clk),
    .arst_n(arst_n),
    .pos_excursion(pos_excursion),
    .restore_r(restore_r)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence read_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence

  read_wait_one_a: assert property (
    (accept && !hwrite && hreadyout) |=> read_wait_s)
    else $error("read wait state not exactly one cycle");
  fixed_freq_a: assert property (
    (hop_mode_select_r == hop_pkg::MODE_OFF) [*2] |=>
      idle_cycles_r == $past(pri_eff))
    else $error("mode off idle differs from primary");
  no_hop_calib_a: assert property (
    (hop_mode_noise && calib_busy) |=> !hop_r)
    else $error("hop during calibration");
  recal_mode_a: assert property (
    recal_all_r |-> ($past(hop_mode_select_r) == hop_pkg::MODE_RECAL
      && hop_r))
    else $error("recalibration outside recal mode");
  adjust_mode_a: assert property (
    adjust_ref_r |-> ($past(hop_mode_select_r) == hop_pkg::MODE_ADJUST
      && hop_r))
    else $error("adjust outside adjust mode");
  sweep_refs_a: assert property (
    (hop_mode_select_r == hop_pkg::MODE_SWEEP) |=>
      (!recal_all_r && !adjust_ref_r))
    else $error("reference change in sweep");
  sweep_step_a: assert property (
    (hop_mode_select_r == hop_pkg::MODE_SWEEP && scan_end) [*1] ##1
      (hop_mode_select_r == hop_pkg::MODE_SWEEP) |->
      (sweep_r == $past(sweep_r) + 9'h001 ||
       sweep_r == $past(sweep_r) - 9'h001))
    else $error("sweep step not one cycle");
  rotate_a: assert property (
    (hop_go && rot_idx_r == 2'h2) |=> rot_idx_r == 2'h0)
    else $error("rotation did not wrap");
  hop_needs_noise_a: assert property (
    (hop_mode_noise && scan_end &&
      pos_count < noise_integrator_limit) |=> !hop_r)
    else $error("hop below integrator limit");

  // Checks on the gap length, the rotation and the requests that follow a hop.
  // A stored zero must stand for the longest gap, not the shortest.
  zero_long_gap_a: assert property (
    (hop_mode_select_r == hop_pkg::MODE_OFF &&
      delay_setting_primary_r == 8'h00) |=> idle_cycles_r == 9'h100)
    else $error("zero primary setting not the longest gap");
  // Before any hop the noise modes burst at the primary setting.
  rot_pri_gap_a: assert property (
    (hop_mode_noise && rot_idx_r == 2'h0) |=>
      idle_cycles_r == $past(pri_eff))
    else $error("noise mode gap differs from primary");
  // A hop below the last setting moves exactly one place on.
  rotate_step_a: assert property (
    (hop_go && rot_idx_r != 2'h2) |=>
      rot_idx_r == $past(rot_idx_r) + 2'h1)
    else $error("rotation skipped a setting");
  // A hop must always carry the reference request of its mode.
  hop_recal_a: assert property (
    (hop_go && hop_mode_select_r == hop_pkg::MODE_RECAL) |=>
      (recal_all_r && hop_r))
    else $error("hop without recalibration request");
  hop_adjust_a: assert property (
    (hop_go && hop_mode_select_r == hop_pkg::MODE_ADJUST) |=>
      (adjust_ref_r && hop_r))
    else $error("hop without reference adjustment");
  // Outside the noise modes the rotation rests on the primary setting.
  rot_rest_a: assert property (
    !hop_mode_noise |=> rot_idx_r == 2'h0)
    else $error("rotation moved outside noise modes");
endmodule
`default_nettype wire

// [bench/host_model.sv]
/*
  Host model: an AHB-Lite master that makes single word transfers.
  Assumes one slave, whose hreadyout is fed back to it as hready.
*/
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock.
  input wire logic clk,
  // Slave answer.
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Master request.
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // The bus stays idle until the first transfer is asked for.
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Each phase is held until hready is sampled high, so a slow slave is safe.
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
/*
  Self-checking bench for the burst frequency hop controller.
  Assumes the host model for register access; the bench drives acquisition.
*/
`timescale 1ns/100ps
`default_nettype none
`include "hop_defines.svh"
module tb;
  logic clk;
  logic arst_n;
  logic hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic delta_valid, scan_end, calib_busy, pos_excursion;
  logic signed [15:0] delta;
  logic [8:0] idle_cycles_r;
  logic hop_r, recal_all_r, adjust_ref_r, restore_r, seen;
  logic [7:0] off1, off2;
  logic [8:0] e;
  logic up;
  int n_fail, cmp_count, cyc, k;
  logic [7:0] ridx [4] = '{`IDX_DELAY_PRI, `IDX_DELAY_SEC,
                           `IDX_DELAY_TER, `IDX_NOISE_CFG};
  logic [7:0] rval [4] = '{8'h01, 8'h06, 8'h3f, 8'h32};
  logic [3:0] tidx [2] = '{4'h0, 4'hf};
  logic [15:0] thr [2] = '{16'h0005, 16'h0032};
  logic [8:0] ei [3] = '{9'h004, 9'h006, 9'h03f};

  burst_frequency_hop_control #(.RESTORE_CYCLES(20))
    burst_frequency_hop_control_inst (
    .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .delta_valid(delta_valid), .delta(delta),
    .scan_end(scan_end), .calib_busy(calib_busy),
    .pos_excursion(pos_excursion), .idle_cycles_r(idle_cycles_r),
    .hop_r(hop_r), .recal_all_r(recal_all_r), .adjust_ref_r(adjust_ref_r),
    .freq_offset_first_r(off1), .freq_offset_second_r(off2),
    .restore_r(restore_r));

  host_model host_model_inst (
    .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  // Free-running clock, 50 ns period.
  always #25 clk = ~clk;

  // A hung handshake would stall forever, so cycles are capped.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  // Counts the compare and reports a mismatch at once.
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host_model_inst.xfer(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx);
    host_model_inst.xfer(1'b0, idx, 8'h00, q);
  endtask

  // Positive deltas first, then negative ones of the same size.
  task automatic pump(input int np, input int nn, input logic [15:0] m);
    repeat (np) begin
      @(posedge clk);
      delta_valid <= 1'b1;
      delta <= m;
    end
    repeat (nn) begin
      @(posedge clk);
      delta_valid <= 1'b1;
      delta <= -m;
    end
    @(posedge clk);
    delta_valid <= 1'b0;
  endtask

  // Pulses and level are looked at in the cycles the hand-over fixes.
  task automatic scan(input logic h, input logic r, input logic a,
                      input logic [8:0] x);
    @(posedge clk);
    scan_end <= 1'b1;
    @(posedge clk);
    scan_end <= 1'b0;
    #1;
    chk(hop_r, h);
    chk(recal_all_r, r);
    chk(adjust_ref_r, a);
    @(posedge clk);
    #1;
    chk(idle_cycles_r, x);
    chk(hop_r, 1'b0);
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence of register and acquisition scenarios.
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    delta_valid = 1'b0;
    delta = 16'sh0;
    scan_end = 1'b0;
    calib_busy = 1'b0;
    pos_excursion = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ridx[i]);
      chk(q, {24'h0, rval[i]});
    end
    rd(`IDX_HOP_MODE);
    chk(q[7:6], 2'h3);
    rd(8'hf9);
    chk(q, 32'h0);
    wr(`IDX_OFFSET_FIRST, 8'hff);
    wr(`IDX_OFFSET_SECOND, 8'h80);
    rd(`IDX_OFFSET_FIRST);
    chk({q[7:0], off1, off2}, 24'hffff80);
    pump(3, 3, 16'h0032);
    rd(`IDX_STATUS);
    chk(q[16:9], 8'h00);
    // Default sweep from 1 to 6 and back.
    e = 9'h001;
    up = 1'b1;
    for (int i = 0; i < 12; i++) begin
      e = up ? e + 9'h001 : e - 9'h001;
      if (e >= 9'h006) up = 1'b0;
      else if (e <= 9'h001) up = 1'b1;
      scan(1'b1, 1'b0, 1'b0, e);
    end
    wr(`IDX_HOP_MODE, 8'h00);
    wr(`IDX_DELAY_PRI, 8'h00);
    wr(`IDX_DELAY_SEC, 8'h02);
    repeat (3) @(posedge clk);
    chk(idle_cycles_r, 9'h100);
    pump(3, 3, 16'h0032);
    scan(1'b0, 1'b0, 1'b0, 9'h100);
    wr(`IDX_DELAY_PRI, 8'h04);
    wr(`IDX_DELAY_SEC, 8'h06);
    repeat (3) @(posedge clk);
    chk(idle_cycles_r, 9'h004);
    wr(`IDX_HOP_MODE, 8'h40);
    pump(3, 2, 16'h000b);
    scan(1'b0, 1'b0, 1'b0, 9'h004);
    pump(2, 3, 16'h000b);
    rd(`IDX_STATUS);
    chk(q[16:9], 8'h23);
    scan(1'b0, 1'b0, 1'b0, 9'h004);
    pump(1, 0, 16'h000b);
    scan(1'b0, 1'b0, 1'b0, 9'h004);
    pump(3, 3, 16'h000a);
    scan(1'b0, 1'b0, 1'b0, 9'h004);
    for (int i = 1; i < 4; i++) begin
      pump(3, 3, 16'h000b);
      scan(1'b1, 1'b1, 1'b0, ei[i % 3]);
    end
    wr(`IDX_HOP_MODE, 8'h80);
    @(posedge clk);
    calib_busy <= 1'b1;
    pump(4, 4, 16'h0020);
    scan(1'b0, 1'b0, 1'b0, 9'h004);
    @(posedge clk);
    calib_busy <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr(`IDX_NOISE_CFG, {4'h3, tidx[i]});
      pump(3, 3, thr[i] - 16'h0001);
      scan(1'b0, 1'b0, 1'b0, ei[i]);
      pump(3, 3, thr[i]);
      scan(1'b1, 1'b0, 1'b1, ei[i + 1]);
    end
    // A short excursion must not restore; a long one must.
    @(posedge clk);
    pos_excursion <= 1'b1;
    repeat (10) @(posedge clk);
    pos_excursion <= 1'b0;
    seen = 1'b0;
    repeat (30) begin
      @(posedge clk);
      seen = seen | restore_r;
    end
    chk(seen, 1'b0);
    pos_excursion <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (restore_r !== 1'b1 && k < 40);
    chk(k >= 20 && k <= 23, 1'b1);
    pos_excursion <= 1'b0;
    chk(hresp, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
